//--- bench/conv_model.sv
// Behavioural converter front end.
`timescale 1ns/1ns
`default_nettype none
module conv_model (
  // Handshake.
  input  wire logic        clk_i,
  input  wire logic        start_i,
  output logic             done_o,
  // Result and delay.
  input  wire logic [10:0] value_i,
  input  wire logic [2:0]  wait_i,
  output logic [10:0]      data_o
);
  initial begin
    done_o = 1'b0;
    data_o = 11'h000;
    forever begin
      @(posedge clk_i);
      if (start_i) begin
        repeat (wait_i) @(posedge clk_i);
        #1 done_o = 1'b1;
        data_o = value_i;
        @(posedge clk_i);
        #1 done_o = 1'b0;
        data_o = ~data_o;
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/temperature_result_formatter_bench.sv
// Self-checking bench of the result formatter.
`timescale 1ns/1ns
`default_nettype none
`include "temp_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module temperature_result_formatter_bench;
  import temp_fmt_pkg::*;
  logic        ref_clk_i, rst_i, conv_start_o, conv_done_i, reg_rd_i;
  logic [1:0]  conv_chan_o;
  logic [2:0]  cwait;
  logic [7:0]  reg_addr_i, reg_rdata_o;
  logic [7:0]  tbl [5];
  logic [9:0]  local_temp_o;
  logic [10:0] conv_data_i, cvalue, d, remote1_temp_o, remote2_temp_o;
  logic [31:0] seed;
  int          loc, ch, n_res, bad_count, checks;
  int          rem [2];
  int          samp [2][$];
  int          gap;
  localparam int SLOT = 4;
  temperature_result_formatter #(.SLOT_CYCLES(SLOT)) i_dut (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .local_temp_o(local_temp_o),
    .remote1_temp_o(remote1_temp_o), .remote2_temp_o(remote2_temp_o));
  conv_model i_conv (.clk_i(ref_clk_i), .start_i(conv_start_o), .done_o(conv_done_i),
    .value_i(cvalue), .wait_i(cwait), .data_o(conv_data_i));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    case (a)
      `OFS_LOCAL_INT:   return loc[9:2];
      `OFS_REMOTE1_INT: return rem[0][10:3];
      `OFS_REMOTE2_INT: return rem[1][10:3];
      `OFS_EXT_RES:     return {loc[1:0], rem[1][2:0], rem[0][2:0]};
      default:          return 8'h00;
    endcase
  endfunction
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    @(posedge ref_clk_i);
    #1;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge ref_clk_i);
    e = exp_reg(a);
    @(posedge ref_clk_i);
    #1;
    reg_rd_i = 1'b0;
    @(negedge ref_clk_i);
    `CHK(reg_rdata_o, e)
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Random converter results and delays.
  always @(posedge ref_clk_i) begin
    #1;
    seed = nx(seed);
    cvalue = seed[10:0];
    cwait = seed[14:12];
  end
  // Reference model updated at every taken result.
  always @(posedge ref_clk_i) begin
    if (conv_done_i && !rst_i) begin
      `CHK(conv_chan_o, ch[1:0])
      d = conv_data_i;
      #2;
      if (ch == 0) loc = $signed(d[9:0]);
      else begin
        samp[ch-1].push_back($signed(d));
        if (samp[ch-1].size() == 16) begin
          rem[ch-1] = samp[ch-1].sum() >>> 4;
          samp[ch-1].delete();
        end
      end
      ch = (ch + 1) % 3;
      n_res++;
      `CHK(local_temp_o, loc[9:0])
      `CHK(remote1_temp_o, rem[0][10:0])
      `CHK(remote2_temp_o, rem[1][10:0])
    end
  end
  // Each start follows reset or the taken result by exactly one slot.
  always @(negedge ref_clk_i) begin
    if (conv_start_o) `CHK(gap, SLOT)
    gap = (conv_done_i || rst_i) ? 0 : gap + 1;
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Watchdog sized at about fourteen times the expected run.
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial begin
    {loc, ch, n_res, bad_count, checks} = '0;
    rem = '{0, 0};
    tbl = '{`OFS_LOCAL_INT, `OFS_REMOTE1_INT, `OFS_REMOTE2_INT, `OFS_EXT_RES, 8'h3f};
    seed = 32'ha2f0;
    rst_i = 1'b1;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    repeat (4) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    @(negedge ref_clk_i);
    `CHK(conv_chan_o, 2'h0)
    `CHK({local_temp_o, remote1_temp_o, remote2_temp_o}, 32'h0)
    $display("test reset done");
    while (n_res < 150) rd(tbl[seed[22:20] % 5]);
    $display("test traffic done");
    print_verdict();
  end
endmodule
`default_nettype wire

//--- hdl/temp_fmt_pkg.sv
// Types shared by the temperature result formatter.
`include "temp_regs.svh"
package temp_fmt_pkg;
  typedef enum logic [1:0] {CH_LOCAL, CH_REMOTE1, CH_REMOTE2} chan_t;
  typedef enum logic {S_WAIT, S_CONV} seq_t;
  typedef struct packed {
    seq_t                          st;
    chan_t                         chan;
    logic [`TIMER_W-1:0]           timer;
    logic                          start;
    logic [1:0]                    pub;
    logic [1:0][`CNT_W-1:0]        cnt;
    logic [1:0][`ACC_W-1:0]        acc;
    logic [1:0][`REMOTE_W-1:0]     rem;
    logic [`LOCAL_W-1:0]           local_t;
    logic [`DATA_W-1:0]            rdata;
  } fmt_state_t;
endpackage

//--- hdl/temp_regs.svh
// Register offsets, field positions, widths and timing figures of the result formatter.
`ifndef TEMP_REGS_SVH
`define TEMP_REGS_SVH
`define ADDR_W            8
`define DATA_W            8
`define OFS_LOCAL_INT     8'h0a
`define OFS_REMOTE1_INT   8'h0b
`define OFS_REMOTE2_INT   8'h0c
`define OFS_EXT_RES       8'h06
`define LOCAL_W           10
`define REMOTE_W          11
`define ACC_W             15
`define AVG_SHIFT         4
`define AVG_COUNT         16
`define NUM_CHAN          3
`define CNT_W             4
`define CNT_LAST          4'hf
`define TIMER_W           16
`define LOCAL_FRAC_W      2
`define REMOTE_FRAC_W     3
`define EXT_LOCAL_LSB     6
`define EXT_R2_LSB        3
`define EXT_R1_LSB        0
`define MEAS_TIME_US      9600
`define CLK_MHZ           100
`define RST_BYTE          8'h00
`endif

//--- hdl/temperature_result_formatter.sv
// Sequencer, averager and register read port of the three-channel temperature back end.
//
// Overview of operation
// - Local result is kept as a ten-bit signed two's complement value.
// - Local fractional bits are two, each step a quarter degree.
// - Every channel's integer part reads as an eight-bit signed byte.
// - Each remote result is an eleven-bit signed two's complement value.
// - One remote step is an eighth degree, spanning minus 128 to 127.875.
// - Remote fractional bits are three, binary eighths of a degree.
// - All fractional bits share one extended-resolution register at 0x06.
// - Each published remote result is the mean of sixteen raw conversions.
// - A full remote measurement with averaging nominally takes 9.6 ms.
// - Two independent remote channels each hold their own stored result.
`timescale 1ns/1ns
`default_nettype none
`include "temp_regs.svh"
module temperature_result_formatter
  import temp_fmt_pkg::*;
#(
  parameter int SLOT_CYCLES = `MEAS_TIME_US * `CLK_MHZ / (`AVG_COUNT * `NUM_CHAN)
) (
  // Clock and reset.
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_i,
  // Converter front end.
  output logic                      conv_start_o,
  output logic [1:0]                conv_chan_o,
  input  wire logic                 conv_done_i,
  input  wire logic [`REMOTE_W-1:0] conv_data_i,
  // Register read port.
  input  wire logic                 reg_rd_i,
  input  wire logic [`ADDR_W-1:0]   reg_addr_i,
  output logic [`DATA_W-1:0]        reg_rdata_o,
  // Full-width results.
  output logic [`LOCAL_W-1:0]       local_temp_o,
  output logic [`REMOTE_W-1:0]      remote1_temp_o,
  output logic [`REMOTE_W-1:0]      remote2_temp_o
);

  fmt_state_t cur;
  fmt_state_t next_cur;

  // Returns the channel that follows in the rotation.
  function automatic chan_t chan_after(input chan_t c);
    chan_t n;
    n = CH_LOCAL;
    case (c)
      CH_LOCAL:   n = CH_REMOTE1;
      CH_REMOTE1: n = CH_REMOTE2;
      default:    n = CH_LOCAL;
    endcase
    return n;
  endfunction

  // Returns the register byte seen at an address.
  function automatic logic [`DATA_W-1:0] reg_value(
    input logic [`ADDR_W-1:0]       a,
    input logic [`LOCAL_W-1:0]      lt,
    input logic [1:0][`REMOTE_W-1:0] rt
  );
    logic [`DATA_W-1:0] v;
    v = `RST_BYTE;
    if (a == `OFS_LOCAL_INT) begin
      v = lt[`LOCAL_W-1:`LOCAL_FRAC_W];
    end else if (a == `OFS_REMOTE1_INT) begin
      v = rt[0][`REMOTE_W-1:`REMOTE_FRAC_W];
    end else if (a == `OFS_REMOTE2_INT) begin
      v = rt[1][`REMOTE_W-1:`REMOTE_FRAC_W];
    end else if (a == `OFS_EXT_RES) begin
      v[`EXT_LOCAL_LSB +: `LOCAL_FRAC_W] = lt[`LOCAL_FRAC_W-1:0];
      v[`EXT_R2_LSB +: `REMOTE_FRAC_W] = rt[1][`REMOTE_FRAC_W-1:0];
      v[`EXT_R1_LSB +: `REMOTE_FRAC_W] = rt[0][`REMOTE_FRAC_W-1:0];
    end
    return v;
  endfunction

  always_comb begin
    logic [`ACC_W-1:0] sum;
    logic              idx;
    sum = '0;
    idx = 1'b0;
    next_cur = cur;
    next_cur.start = 1'b0;
    next_cur.pub = '0;
    case (cur.st)
      S_WAIT: begin
        // Each visit waits one slot; sixteen rotations of three slots span one measurement.
        if (cur.timer == `TIMER_W'(SLOT_CYCLES - 1)) begin
          next_cur.timer = '0;
          next_cur.start = 1'b1;
          next_cur.st = S_CONV;
        end else begin
          next_cur.timer = cur.timer + `TIMER_W'(1);
        end
      end
      S_CONV: begin
        if (conv_done_i) begin
          if (cur.chan == CH_LOCAL) begin
            next_cur.local_t = conv_data_i[`LOCAL_W-1:0];
          end else begin
            idx = (cur.chan == CH_REMOTE2);
            sum = cur.acc[idx] + {{(`ACC_W - `REMOTE_W){conv_data_i[`REMOTE_W-1]}}, conv_data_i};
            if (cur.cnt[idx] == `CNT_LAST) begin
              next_cur.rem[idx] = sum[`ACC_W-1:`AVG_SHIFT];
              next_cur.acc[idx] = '0;
              next_cur.pub[idx] = 1'b1;
            end else begin
              next_cur.acc[idx] = sum;
            end
            next_cur.cnt[idx] = cur.cnt[idx] + `CNT_W'(1);
          end
          next_cur.chan = chan_after(cur.chan);
          next_cur.st = S_WAIT;
        end
      end
      default: begin
        next_cur.st = S_WAIT;
      end
    endcase
    if (reg_rd_i) begin
      next_cur.rdata = reg_value(reg_addr_i, cur.local_t, cur.rem);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign conv_start_o   = cur.start;
  assign conv_chan_o    = cur.chan;
  assign reg_rdata_o    = cur.rdata;
  assign local_temp_o   = cur.local_t;
  assign remote1_temp_o = cur.rem[0];
  assign remote2_temp_o = cur.rem[1];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence read_of(logic [`ADDR_W-1:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence

  sequence local_done;
    cur.st == S_CONV && conv_done_i && cur.chan == CH_LOCAL;
  endsequence

  sequence result_taken;
    cur.st == S_CONV && conv_done_i;
  endsequence

  sequence remote_taken(chan_t c);
    cur.st == S_CONV && conv_done_i && cur.chan == c;
  endsequence

  sequence slot_end;
    cur.st == S_WAIT && cur.timer == `TIMER_W'(SLOT_CYCLES - 1);
  endsequence

  a_start_pulse_once: assert property (conv_start_o |=> !conv_start_o)
    else $error("Converter start held longer than one cycle.");
  a_round_robin_order: assert property (
    result_taken |=> chan_t'(conv_chan_o) == chan_after($past(cur.chan)))
    else $error("Channel visit order broken.");
  a_slot_spacing: assert property (
    conv_start_o |-> $past(cur.timer) == `TIMER_W'(SLOT_CYCLES - 1))
    else $error("Conversion started before its slot elapsed.");
  a_local_capture: assert property (
    local_done |=> local_temp_o == $past(conv_data_i[`LOCAL_W-1:0]))
    else $error("Local result not captured.");
  a_local_int_byte: assert property (
    read_of(`OFS_LOCAL_INT) |=> reg_rdata_o == $past(cur.local_t[`LOCAL_W-1:`LOCAL_FRAC_W]))
    else $error("Local integer byte wrong.");
  a_ext_frac_bits: assert property (
    read_of(`OFS_EXT_RES) |=>
      reg_rdata_o[`EXT_LOCAL_LSB +: `LOCAL_FRAC_W] == $past(cur.local_t[`LOCAL_FRAC_W-1:0])
      && reg_rdata_o[`EXT_R1_LSB +: `REMOTE_FRAC_W] == $past(cur.rem[0][`REMOTE_FRAC_W-1:0])
      && reg_rdata_o[`EXT_R2_LSB +: `REMOTE_FRAC_W] == $past(cur.rem[1][`REMOTE_FRAC_W-1:0]))
    else $error("Extended resolution register wrong.");

  a_start_after_slot: assert property (
    slot_end
    |=> conv_start_o)
    else $error("Conversion not started at the end of its slot.");

  a_wait_no_start: assert property (
    cur.st == S_WAIT
    |-> !conv_start_o)
    else $error("Conversion started while waiting.");

  a_timer_in_range: assert property (
    cur.timer <= `TIMER_W'(SLOT_CYCLES - 1))
    else $error("Slot timer ran past its end.");

  a_start_enters_conv: assert property (
    conv_start_o
    |-> cur.st == S_CONV && cur.timer == '0)
    else $error("Start pulse outside the conversion state.");

  a_wait_after_take: assert property (
    result_taken
    |=> cur.st == S_WAIT && cur.timer == '0)
    else $error("Sequencer did not return to waiting after a result.");

  a_conv_waits_done: assert property (
    cur.st == S_CONV && !conv_done_i
    |=> cur.st == S_CONV)
    else $error("Conversion left without a result.");

  a_chan_held: assert property (
    !(cur.st == S_CONV && conv_done_i)
    |=> $stable(conv_chan_o))
    else $error("Channel changed without a result.");

  a_chan_legal: assert property (
    chan_t'(conv_chan_o) inside {CH_LOCAL, CH_REMOTE1, CH_REMOTE2})
    else $error("Channel outside the three visited channels.");

  a_local_held: assert property (
    !(cur.st == S_CONV && conv_done_i && cur.chan == CH_LOCAL)
    |=> $stable(local_temp_o))
    else $error("Local result changed without a local result.");

  a_local_rem_untouched: assert property (
    local_done
    |=> $stable(cur.rem))
    else $error("Local result disturbed a remote result.");

  a_pub_exclusive: assert property (
    !(cur.pub[0] && cur.pub[1]))
    else $error("Both remote channels published together.");

  a_local_sign_byte: assert property (
    read_of(`OFS_LOCAL_INT)
    |=> reg_rdata_o[`DATA_W-1] == $past(cur.local_t[`LOCAL_W-1]))
    else $error("Local integer byte lost its sign.");

  a_rdata_holds: assert property (
    !reg_rd_i
    |=> $stable(reg_rdata_o))
    else $error("Read data changed without a read.");

  a_unmapped_zero: assert property (
    reg_rd_i && !(reg_addr_i inside {`OFS_LOCAL_INT, `OFS_REMOTE1_INT,
                                     `OFS_REMOTE2_INT, `OFS_EXT_RES})
    |=> reg_rdata_o == `RST_BYTE)
    else $error("Unmapped address did not read zero.");

  generate
    for (genvar g = 0; g < 2; g++) begin : g_rem
      localparam chan_t own_chan = g ? CH_REMOTE2 : CH_REMOTE1;
      a_avg_sixteen: assert property (
        cur.pub[g] |-> cur.cnt[g] == '0 && cur.acc[g] == '0)
        else $error("Remote result published off the sixteenth sample.");
      a_rem_only_on_pub: assert property (
        !$stable(cur.rem[g]) |-> cur.pub[g])
        else $error("Remote result changed outside a publish.");
      a_rem_int_byte: assert property (
        read_of(g ? `OFS_REMOTE2_INT : `OFS_REMOTE1_INT) |=>
          reg_rdata_o == $past(cur.rem[g][`REMOTE_W-1:`REMOTE_FRAC_W]))
        else $error("Remote integer byte wrong.");

      a_cnt_steps: assert property (
        remote_taken(own_chan)
        |=> cur.cnt[g] == $past(cur.cnt[g]) + `CNT_W'(1))
        else $error("Remote sample count did not step.");

      a_pub_on_last: assert property (
        remote_taken(own_chan) ##0 cur.cnt[g] == `CNT_LAST
        |=> cur.pub[g])
        else $error("Sixteenth remote sample not published.");

      a_pub_needs_last: assert property (
        cur.pub[g]
        |-> $past(cur.cnt[g]) == `CNT_LAST)
        else $error("Remote result published early.");

      a_pub_after_take: assert property (
        cur.pub[g]
        |-> $past(conv_done_i) && $past(cur.chan) == own_chan)
        else $error("Remote result published without its own sample.");

      a_cnt_idle: assert property (
        !(cur.st == S_CONV && conv_done_i && cur.chan == own_chan)
        |=> $stable(cur.cnt[g]) && $stable(cur.acc[g]))
        else $error("Remote accumulator moved without a result for it.");

      a_pub_single: assert property (
        cur.pub[g]
        |=> !cur.pub[g])
        else $error("Remote publish held longer than one cycle.");

      a_acc_signed: assert property (
        remote_taken(own_chan) ##0 cur.cnt[g] != `CNT_LAST
        |=> $signed(cur.acc[g]) == $signed($past(cur.acc[g])) + $signed($past(conv_data_i)))
        else $error("Remote sample not added as a signed value.");

      a_rem_frac_read: assert property (
        read_of(`OFS_EXT_RES)
        |=> reg_rdata_o[(g ? `EXT_R2_LSB : `EXT_R1_LSB) +: `REMOTE_FRAC_W]
            == $past(cur.rem[g][`REMOTE_FRAC_W-1:0]))
        else $error("Remote fractional bits read wrong.");
    end
  endgenerate

endmodule
`default_nettype wire
